// [hdl/sac_adc_ctrl.sv]
`timescale 1ns/100ps
module sac_adc_ctrl
  import sac_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] bus_addr,
  input wire logic bus_wr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_bit_wr,
  input wire logic [2:0] bus_bit_sel,
  input wire logic bus_bit_val,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic standby,
  input wire logic flag_clr,
  input wire logic ana_cmp_ge,
  output logic [2:0] ana_chan_sel,
  output logic ana_sample,
  output logic [7:0] ana_tap,
  output logic conv_busy,
  output logic conversion_done_irq,
  output logic conversion_done_flag
);

  generate
    if (CNT_W < 6 || CNT_W > 8) begin : g_bad_cnt
      $error("CNT_W must be 6 to 8");
    end
  endgenerate

  typedef struct packed {
    logic [7:0] mode;
    logic [2:0] chan;
    sac_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [2:0] bitn;
    logic [7:0] sar;
    logic irq;
    logic flag;
    logic [7:0] rdata;
  } sac_ctrl_t;

  localparam sac_ctrl_t CTRL_RST = '{
    mode: MODE_RST, chan: CHAN_RST, st: ST_IDLE, cnt: '0, bitn: MSB_IDX,
    sar: 8'h00, irq: 1'b0, flag: 1'b0, rdata: READ_IDLE};

  sac_ctrl_t s_r;
  sac_ctrl_t s_nxt;
  sac_res_if res_if ();

  logic mode_wr;
  logic chan_wr;
  logic cfg_wr;
  logic en_nxt;
  logic start;
  logic load;
  logic [7:0] new_mode;
  logic [7:0] new_chan;
  logic [7:0] decided;
  logic [7:0] step_len;

  // Byte write replaces, bit write changes one bit only
  function automatic logic [7:0] merge_write(input logic [7:0] old,
      input logic byte_wr, input logic [7:0] wdata,
      input logic [2:0] sel, input logic val);
    logic [7:0] v;
    v = old;
    if (byte_wr) begin
      v = wdata;
    end else begin
      v[sel] = val;
    end
    merge_write = v;
  endfunction

  assign mode_wr = (bus_wr || bus_bit_wr) && bus_addr == ADDR_MODE;
  assign chan_wr = (bus_wr || bus_bit_wr) && bus_addr == ADDR_CHAN;
  assign cfg_wr = mode_wr || chan_wr;

  assign new_mode = merge_write(s_r.mode, bus_wr, bus_wdata, bus_bit_sel,
                                bus_bit_val) & MODE_WMASK;
  assign new_chan = merge_write({5'h00, s_r.chan}, bus_wr, bus_wdata,
                                bus_bit_sel, bus_bit_val) & CHAN_WMASK;
  assign en_nxt = mode_wr ? new_mode[MODE_EN_BIT] : s_r.mode[MODE_EN_BIT];

  assign step_len = sac_step_cycles(mode_wr ? new_mode[5:3]
                                            : s_r.mode[5:3]);

  // keep bit when input at least tap
  assign decided = ana_cmp_ge ? s_r.sar
                              : (s_r.sar & ~(8'h01 << s_r.bitn));

  always_comb begin
    s_nxt = s_r;
    start = 1'b0;
    load = 1'b0;
    s_nxt.irq = 1'b0;
    // read sees the value before any load this cycle
    if (bus_rd) begin
      case (bus_addr)
        ADDR_MODE: s_nxt.rdata = s_r.mode;
        ADDR_CHAN: s_nxt.rdata = {5'h00, s_r.chan};
        ADDR_RESULT: s_nxt.rdata = res_if.q;
        default: s_nxt.rdata = READ_IDLE;
      endcase
    end
    if (mode_wr) begin
      s_nxt.mode = new_mode;
    end
    if (chan_wr) begin
      s_nxt.chan = new_chan[2:0];
    end
    if (standby || !en_nxt) begin
      s_nxt.st = ST_IDLE;
      s_nxt.cnt = '0;
    end else if (cfg_wr || s_r.st == ST_IDLE) begin
      start = 1'b1;
    end else begin
      case (s_r.st)
        ST_SAMPLE: begin
          if (s_r.cnt == '0) begin
            s_nxt.st = ST_CONV;
            s_nxt.sar = MSB_SET;
            s_nxt.bitn = MSB_IDX;
            s_nxt.cnt = step_len[CNT_W-1:0] - 1'b1;
          end else begin
            s_nxt.cnt = s_r.cnt - 1'b1;
          end
        end
        ST_CONV: begin
          if (s_r.cnt != '0) begin
            s_nxt.cnt = s_r.cnt - 1'b1;
          end else if (s_r.bitn == 3'h0) begin
            load = 1'b1;
            s_nxt.irq = 1'b1;
            start = 1'b1;
          end else begin
            s_nxt.sar = decided | (8'h01 << (3'(s_r.bitn - 3'h1)));
            s_nxt.bitn = 3'(s_r.bitn - 3'h1);
            s_nxt.cnt = step_len[CNT_W-1:0] - 1'b1;
          end
        end
        default: begin
          s_nxt.st = ST_IDLE;
        end
      endcase
    end
    if (start) begin
      s_nxt.st = ST_SAMPLE;
      s_nxt.sar = 8'h00;
      s_nxt.bitn = MSB_IDX;
      s_nxt.cnt = CNT_W'(step_len * SAMPLE_STEPS - 8'h01);
    end
    // only the clear input lowers the flag; a new result wins
    s_nxt.flag = (s_r.flag && !flag_clr) || load;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= CTRL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign res_if.wr_en = load;
  assign res_if.wr_data = decided;

  sac_result_store u_store (
    .clk(clk),
    .res(res_if.store)
  );

  assign ana_chan_sel = s_r.chan;
  assign ana_sample = s_r.st == ST_SAMPLE;
  assign ana_tap = s_r.sar;
  assign conv_busy = s_r.st != ST_IDLE;
  assign conversion_done_irq = s_r.irq;
  assign conversion_done_flag = s_r.flag;
  assign bus_rdata = s_r.rdata;

  // Cycles since the current conversion started, for checking only
  logic [7:0] age_r;
  always_ff @(posedge clk) begin
    if (!rst_n || start) begin
      age_r <= 8'h00;
    end else if (age_r != 8'hff) begin
      age_r <= age_r + 8'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seq_trial_end;
    s_r.st == ST_CONV && s_r.cnt == '0 && s_r.bitn != 3'h0 &&
      !cfg_wr && en_nxt && !standby;
  endsequence

  sequence seq_last_trial;
    s_r.st == ST_CONV && s_r.cnt == '0 && s_r.bitn == 3'h0 &&
      !cfg_wr && en_nxt && !standby;
  endsequence

  a_reset_clears_regs: assert property (
    $rose(rst_n) |-> s_r.mode == MODE_RST && s_r.chan == CHAN_RST &&
      !conv_busy)
    else $error("registers not cleared by reset");

  a_mode_reserved_zero: assert property (
    (s_r.mode & ~MODE_WMASK) == 8'h00)
    else $error("reserved mode bits not zero");

  a_mode_bit_write: assert property (
    (bus_bit_wr && !bus_wr && bus_addr == ADDR_MODE) |=>
      s_r.mode[$past(bus_bit_sel)] ==
      ($past(bus_bit_val) && MODE_WMASK[$past(bus_bit_sel)]))
    else $error("bit write to mode lost");

  a_cfg_write_restart: assert property (
    (cfg_wr && en_nxt && !standby) |=>
      ana_sample && s_r.sar == 8'h00 && s_r.bitn == MSB_IDX)
    else $error("config write did not restart sampling");

  a_disable_stops_now: assert property (
    (mode_wr && !new_mode[MODE_EN_BIT]) |=> !conv_busy && !ana_sample)
    else $error("disable write did not stop conversion");

  a_standby_stops: assert property (
    standby |=> !conv_busy ##1 (!conv_busy || !$past(standby)))
    else $error("converter runs in standby");

  a_first_trial_msb: assert property (
    (s_r.st == ST_CONV && $past(s_r.st) == ST_SAMPLE) |->
      s_r.sar == MSB_SET && s_r.bitn == MSB_IDX)
    else $error("first trial not at half reference");

  a_bit_decided: assert property (
    seq_trial_end |=> s_r.sar[$past(s_r.bitn)] == $past(ana_cmp_ge) &&
      s_r.sar[$past(s_r.bitn) - 3'h1])
    else $error("trial bit not decided from comparator");

  a_result_with_irq: assert property (
    seq_last_trial |=> conversion_done_irq && conversion_done_flag &&
      res_if.q[0] == $past(ana_cmp_ge) &&
      res_if.q[7:1] == $past(s_r.sar[7:1]))
    else $error("result and request not together");

  a_repeat_sample: assert property (
    conversion_done_irq |-> ana_sample)
    else $error("no repeat after conversion");

  a_conv_total_time: assert property (
    conversion_done_irq |->
      $past(age_r) == sac_conv_cycles($past(s_r.mode[5:3])) - 8'h01)
    else $error("conversion time wrong");

  a_write_drops_load: assert property (
    cfg_wr |=> !conversion_done_irq)
    else $error("request raised despite config write");

  a_flag_held: assert property (
    (conversion_done_flag && !flag_clr) |=> conversion_done_flag)
    else $error("done flag lost without clear");

  a_read_old_result: assert property (
    (bus_rd && bus_addr == ADDR_RESULT) |=> bus_rdata == $past(res_if.q))
    else $error("result read not the old value");

  // sample period
  // A stop or restart may cut sampling short, so only a hand-over to hold
  // is timed
  a_sample_hold_time: assert property (
    ($fell(ana_sample) && conv_busy) |->
      age_r == sac_step_cycles(s_r.mode[5:3]) * SAMPLE_STEPS)
    else $error("sampling period wrong");

endmodule // sac_adc_ctrl

// [pkg/sac_pkg.sv]
package sac_pkg;

  localparam logic [15:0] ADDR_MODE = 16'hff80;
  localparam logic [15:0] ADDR_CHAN = 16'hff84;
  localparam logic [15:0] ADDR_RESULT = 16'hff14;

  localparam int MODE_EN_BIT = 7;
  localparam int MODE_FR_LSB = 3;
  localparam logic [7:0] MODE_WMASK = 8'hb8;
  localparam logic [7:0] CHAN_WMASK = 8'h07;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [2:0] CHAN_RST = 3'h0;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // Conversion time in main clock cycles per time code
  localparam logic [7:0] CONV_CYC_144 = 8'h90;
  localparam logic [7:0] CONV_CYC_120 = 8'h78;
  localparam logic [7:0] CONV_CYC_96 = 8'h60;
  localparam logic [7:0] CONV_CYC_72 = 8'h48;
  localparam logic [7:0] CONV_CYC_60 = 8'h3c;
  localparam logic [7:0] CONV_CYC_48 = 8'h30;

  // Time split: sampling takes 4 of 12 equal steps, 8 trials the rest
  localparam logic [7:0] STEP_DIV = 8'h0c;
  localparam logic [7:0] SAMPLE_STEPS = 8'h04;
  localparam logic [7:0] MSB_SET = 8'h80;
  localparam logic [2:0] MSB_IDX = 3'h7;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONV = 2'b10
  } sac_state_t;

  // Prohibited codes fall back to the slowest, safest time
  function automatic logic [7:0] sac_conv_cycles(input logic [2:0] fr);
    case (fr)
      3'h0: sac_conv_cycles = CONV_CYC_144;
      3'h1: sac_conv_cycles = CONV_CYC_120;
      3'h2: sac_conv_cycles = CONV_CYC_96;
      3'h4: sac_conv_cycles = CONV_CYC_72;
      3'h5: sac_conv_cycles = CONV_CYC_60;
      3'h6: sac_conv_cycles = CONV_CYC_48;
      default: sac_conv_cycles = CONV_CYC_144;
    endcase
  endfunction

  function automatic logic [7:0] sac_step_cycles(input logic [2:0] fr);
    sac_step_cycles = sac_conv_cycles(fr) / STEP_DIV;
  endfunction

endpackage

// [pkg/sac_res_if.sv]
`timescale 1ns/100ps
interface sac_res_if;
  logic wr_en;
  logic [7:0] wr_data;
  logic [7:0] q;

  modport ctrl (output wr_en, output wr_data, input q);
  modport store (input wr_en, input wr_data, output q);
endinterface // sac_res_if

// [hdl/sac_result_store.sv]
`timescale 1ns/100ps
module sac_result_store
  import sac_pkg::*;
(
  input wire logic clk,
  sac_res_if.store res
);

  typedef struct packed {
    logic [7:0] value;
  } sac_store_t;

  sac_store_t s_r;
  sac_store_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (res.wr_en) begin
      s_nxt.value = res.wr_data;
    end
  end

  // no reset
  // Left without reset so it holds no defined value until a first result
  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  assign res.q = s_r.value;

endmodule // sac_result_store

// [tb/sac_ana_model.sv]
`timescale 1ns/100ps
module sac_ana_model (
  input wire logic [7:0] vin [8],
  input wire logic [2:0] chan_sel,
  input wire logic sample,
  input wire logic [7:0] tap,
  output logic cmp_ge
);
  // input versus tap
  // Output means nothing while sampling, so it gives the inverted tap bit 0
  assign cmp_ge = sample ? ~tap[0] : (vin[chan_sel] >= tap);
endmodule // sac_ana_model

// [tb/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  import sac_pkg::*;
  logic clk = 0, rst_n = 0;
  logic [15:0] addr = '0;
  logic wr = 0, bwr = 0, bval = 0, rd = 0, stby = 0, fclr = 0;
  logic [7:0] wdata = '0;
  logic [2:0] bsel = '0;
  logic [7:0] rdata, tap, t0, v;
  logic [2:0] csel;
  logic samp, ge, busy, irq, flag;
  logic [7:0] vin [8] = '{8'h5a, 8'h00, 8'ha5, 8'hff, 8'h01, 8'h80, 8'h7f,
    8'h3c};
  int failures = 0, comparisons = 0, cycles = 0, n, ns;
  // only codes of 72 cycles and up
  localparam int cyc [4] = '{144, 120, 96, 72};
  localparam logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
  localparam logic [2:0] chans [4] = '{3'h0, 3'h3, 3'h6, 3'h5};

  always #10 clk = ~clk;

  sac_adc_ctrl sac_adc_ctrl_inst (.clk(clk), .rst_n(rst_n), .bus_addr(addr),
    .bus_wr(wr), .bus_wdata(wdata), .bus_bit_wr(bwr), .bus_bit_sel(bsel),
    .bus_bit_val(bval), .bus_rd(rd), .bus_rdata(rdata), .standby(stby),
    .flag_clr(fclr), .ana_cmp_ge(ge), .ana_chan_sel(csel),
    .ana_sample(samp), .ana_tap(tap), .conv_busy(busy),
    .conversion_done_irq(irq), .conversion_done_flag(flag));

  sac_ana_model sac_ana_model_inst (.vin(vin), .chan_sel(csel),
    .sample(samp), .tap(tap), .cmp_ge(ge));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (failures == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1;
    @(negedge clk);
    wr = 0;
  endtask

  task automatic bit_wr(input logic [2:0] s, input logic b);
    addr = ADDR_MODE;
    bsel = s;
    bval = b;
    bwr = 1;
    @(negedge clk);
    bwr = 0;
  endtask

  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
    addr = a;
    rd = 1;
    @(negedge clk);
    rd = 0;
    d = rdata;
    // Idle cycle so a following read never re-raises rd in this step
    @(negedge clk);
  endtask

  // Edges to the request, sampling cycles, first trial tap
  task automatic wait_irq();
    n = 0;
    ns = 0;
    do begin
      @(negedge clk);
      n++;
      if (samp === 1'b1 && irq !== 1'b1) ns++;
      if (samp === 1'b0 && n == ns + 1) t0 = tap;
    end while (irq !== 1'b1 && n < 300);
  endtask

  task automatic stop_conv();
    wr_reg(ADDR_MODE, 8'h00);
    @(negedge clk);
    chk(16'(busy), 16'h0);
  endtask

  task automatic t_reset();
    rd_reg(ADDR_MODE, v);
    chk(16'(v), 16'h0);
    rd_reg(ADDR_CHAN, v);
    chk(16'(v), 16'h0);
    chk(16'(csel), 16'h0);
    rd_reg(16'hff00, v);
    chk(16'(v), 16'h0);
    chk(16'(busy), 16'h0);
  endtask

  task automatic t_regs();
    wr_reg(ADDR_MODE, 8'hff);
    chk(16'(busy), 16'h1);
    rd_reg(ADDR_MODE, v);
    chk(16'(v), 16'hb8);
    stop_conv();
    wr_reg(ADDR_CHAN, 8'hff);
    rd_reg(ADDR_CHAN, v);
    chk(16'(v), 16'h7);
    wr_reg(ADDR_CHAN, 8'h00);
  endtask

  task automatic t_conv(input int i);
    @(negedge clk);
    wr_reg(ADDR_CHAN, {5'h00, chans[i]});
    chk(16'(csel), 16'(chans[i]));
    @(negedge clk);
    wr_reg(ADDR_MODE, {2'b10, codes[i], 3'h0});
    wait_irq();
    chk(16'(n), 16'(cyc[i]));
    // First sampling cycle passes inside the write task, uncounted
    chk(16'(ns), 16'(cyc[i] / 3 - 1));
    chk(16'(t0), 16'h80);
    chk(16'(flag), 16'h1);
    wait_irq();
    chk(16'(n), 16'(cyc[i]));
    rd_reg(ADDR_RESULT, v);
    chk(16'(v), 16'(vin[chans[i]]));
    stop_conv();
  endtask

  task automatic t_bit();
    fclr = 1;
    @(negedge clk);
    fclr = 0;
    chk(16'(flag), 16'h0);
    bit_wr(3'h7, 1'b1);
    wait_irq();
    chk(16'(n), 16'd144);
    bit_wr(3'h7, 1'b0);
    @(negedge clk);
    chk(16'(busy), 16'h0);
    chk(16'(flag), 16'h1);
    wait_irq();
    chk(16'(n), 16'd300);
  endtask

  task automatic t_abort();
    wr_reg(ADDR_MODE, 8'h80);
    repeat (100) @(negedge clk);
    wr_reg(ADDR_CHAN, 8'h02);
    wait_irq();
    chk(16'(n), 16'd144);
    chk(16'(t0), 16'h80);
    wait_irq();
    rd_reg(ADDR_RESULT, v);
    chk(16'(v), 16'(vin[2]));
    stop_conv();
  endtask

  task automatic t_standby();
    wr_reg(ADDR_MODE, 8'h80);
    repeat (50) @(negedge clk);
    stby = 1;
    @(negedge clk);
    @(negedge clk);
    chk(16'(busy), 16'h0);
    wait_irq();
    chk(16'(n), 16'd300);
    stby = 0;
    stop_conv();
  endtask

  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1;
    t_reset();
    t_regs();
    for (int i = 0; i < 4; i++) begin
      t_conv(i);
    end
    t_bit();
    t_abort();
    t_standby();
    give_verdict();
  end
endmodule // tb_top
